// ---- src/pdbmc_line_coder.sv ----
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Toggle line at every bit start
// - One bits add a midpoint toggle
// - Driven level never stands unchanged longer than one bit
// - Preamble begins by driving the line low
// - Closing edge follows the final bit
// - Transmit only on the oriented pin
// - Three-state driver: level plus output enable
// - Release line when not transmitting
// - Pin selection fixed during a connection
// - Only one talker; others stay released
// - Squelch reports idle bus before sending
module pdbmc_line_coder (
	input  wire logic clk_sys,              // System clock, 10 MHz
	input  wire logic rst,                  // Async reset, active high
	input  wire logic attached,             // Connection established
	input  wire logic orient_b,             // Plug mates with channel b
	input  wire logic tx_start,             // Pulse: send a packet
	input  wire logic tx_valid,             // Next payload bit present
	input  wire logic tx_bit,               // Payload bit
	input  wire logic tx_last,              // Bit closes the packet
	output logic      tx_ready,             // Pulse: payload bit taken when tx_valid
	output logic      tx_busy,              // Packet in progress
	input  wire logic config_channel_a_in,  // Pin a level seen
	output logic      config_channel_a_out, // Pin a drive level
	output logic      config_channel_a_oe,  // Pin a driver enable
	input  wire logic config_channel_b_in,  // Pin b level seen
	output logic      config_channel_b_out, // Pin b drive level
	output logic      config_channel_b_oe,  // Pin b driver enable
	output logic      bus_idle,             // Squelch: bus quiet
	output logic      rx_bit,               // Decoded bit
	output logic      rx_valid              // Pulse: rx_bit is new
);
	pdbmc_pkg::pdbmc_tx_e state, next_state;
	logic [7:0] hcnt, next_hcnt;
	logic       phase, next_phase;
	logic       lvl, next_lvl;
	logic       cur_bit, next_cur_bit;
	logic       cur_last, next_cur_last;
	logic [6:0] pcnt, next_pcnt;
	logic       tick, drive, load_pt;

	logic sel_b, next_sel_b, locked, next_locked;

	pdbmc_pkg::pdbmc_rx_e rstate, next_rstate;
	logic [7:0] rcnt, next_rcnt, icnt, next_icnt;
	logic       rx_prev, rx_mid, next_rx_mid;
	logic       next_rx_bit, next_rx_valid, next_bus_idle;
	logic       rx_in, edge_seen;

	assign tick  = (hcnt == pdbmc_pkg::HALF_CYC - 8'h01);
	assign drive = (state == pdbmc_pkg::S_LEAD) || (state == pdbmc_pkg::S_PRE)
		|| (state == pdbmc_pkg::S_DATA) || (state == pdbmc_pkg::S_CLOSE);
	// Payload bit is fetched right at the boundary it is sent from
	assign load_pt = tick && phase && !cur_last
		&& ((state == pdbmc_pkg::S_DATA)
		|| ((state == pdbmc_pkg::S_PRE)
		&& (pcnt == pdbmc_pkg::PRE_BITS - 7'h01)));
	assign tx_ready = load_pt;
	assign tx_busy  = (state != pdbmc_pkg::S_IDLE);

	// Driver is enabled only while sending, on one pin
	assign config_channel_a_oe  = drive && !sel_b;
	assign config_channel_b_oe  = drive && sel_b;
	assign config_channel_a_out = lvl;
	assign config_channel_b_out = lvl;

	always_comb
	begin
		next_sel_b  = sel_b;
		next_locked = attached;
		if (attached && !locked)
			next_sel_b = orient_b;
	end

	always_comb
	begin
		next_state    = state;
		next_hcnt     = tick ? pdbmc_pkg::CNT_ZERO : hcnt + 8'h01;
		next_phase    = phase;
		next_lvl      = lvl;
		next_cur_bit  = cur_bit;
		next_cur_last = cur_last;
		next_pcnt     = pcnt;
		unique case (state)
			pdbmc_pkg::S_IDLE:
			begin
				next_hcnt = pdbmc_pkg::CNT_ZERO;
				if (tx_start && attached)
					next_state = pdbmc_pkg::S_WAIT;
			end
			pdbmc_pkg::S_WAIT:
			begin
				next_hcnt = pdbmc_pkg::CNT_ZERO;
				next_phase = 1'b1;
				next_lvl = 1'b0;
				if (!attached)
					next_state = pdbmc_pkg::S_IDLE;
				else if (bus_idle)
					next_state = pdbmc_pkg::S_LEAD;
			end
			pdbmc_pkg::S_LEAD:
			begin
				next_lvl = 1'b0;
				if (tick)
				begin
					next_state   = pdbmc_pkg::S_PRE;
					next_phase   = 1'b0;
					next_lvl     = 1'b1;
					next_pcnt    = pdbmc_pkg::PCNT_ZERO;
					next_cur_bit = 1'b0;
					next_cur_last = 1'b0;
				end
			end
			pdbmc_pkg::S_PRE, pdbmc_pkg::S_DATA:
			begin
				if (tick && !phase)
				begin
					next_phase = 1'b1;
					if (cur_bit)
						next_lvl = ~lvl;
				end
				else if (tick)
				begin
					next_phase = 1'b0;
					next_lvl = ~lvl;
					if (load_pt && tx_valid)
					begin
						next_state    = pdbmc_pkg::S_DATA;
						next_cur_bit  = tx_bit;
						next_cur_last = tx_last;
					end
					else if (state == pdbmc_pkg::S_PRE && !load_pt)
					begin
						next_pcnt    = pcnt + 7'h01;
						next_cur_bit = ~pcnt[0];
					end
					else
					begin
						// Last bit sent or payload underrun
						next_state = pdbmc_pkg::S_CLOSE;
						next_phase = 1'b1;
					end
				end
			end
			pdbmc_pkg::S_CLOSE:
				if (tick)
					next_state = pdbmc_pkg::S_IDLE;
			default:
				next_state = pdbmc_pkg::S_IDLE;
		endcase
	end

	// Receive from the oriented pin; own transmission is not heard
	assign rx_in     = sel_b ? config_channel_b_in : config_channel_a_in;
	assign edge_seen = (rx_in != rx_prev) && !drive;

	always_comb
	begin
		next_rstate   = rstate;
		next_rcnt     = rcnt + 8'h01;
		next_rx_mid   = rx_mid;
		next_rx_bit   = rx_bit;
		next_rx_valid = 1'b0;
		next_icnt     = edge_seen || drive ? pdbmc_pkg::CNT_ZERO : icnt;
		if (!edge_seen && !drive && icnt != pdbmc_pkg::IDLE_CYC)
			next_icnt = icnt + 8'h01;
		next_bus_idle = (next_icnt == pdbmc_pkg::IDLE_CYC);
		unique case (rstate)
			pdbmc_pkg::R_HUNT:
			begin
				next_rcnt = pdbmc_pkg::CNT_ZERO;
				// Any edge is taken as a boundary; lock follows
				if (edge_seen)
				begin
					next_rstate = pdbmc_pkg::R_BIT;
					next_rx_mid = 1'b0;
				end
			end
			pdbmc_pkg::R_BIT:
			begin
				if (edge_seen && !rx_mid && rcnt < pdbmc_pkg::RX_MID_LIMIT)
					next_rx_mid = 1'b1;
				else if (edge_seen)
				begin
					next_rx_bit   = rx_mid;
					next_rx_valid = 1'b1;
					next_rx_mid   = 1'b0;
					next_rcnt     = pdbmc_pkg::CNT_ZERO;
				end
				else if (rcnt == pdbmc_pkg::RX_TIMEOUT || drive)
					next_rstate = pdbmc_pkg::R_HUNT;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			state    <= pdbmc_pkg::S_IDLE;
			hcnt     <= pdbmc_pkg::CNT_ZERO;
			phase    <= 1'b0;
			lvl      <= 1'b0;
			cur_bit  <= 1'b0;
			cur_last <= 1'b0;
			pcnt     <= pdbmc_pkg::PCNT_ZERO;
			sel_b    <= 1'b0;
			locked   <= 1'b0;
			rstate   <= pdbmc_pkg::R_HUNT;
			rcnt     <= pdbmc_pkg::CNT_ZERO;
			icnt     <= pdbmc_pkg::CNT_ZERO;
			rx_prev  <= 1'b0;
			rx_mid   <= 1'b0;
			rx_bit   <= 1'b0;
			rx_valid <= 1'b0;
			bus_idle <= 1'b0;
		end
		else
		begin
			state    <= next_state;
			hcnt     <= next_hcnt;
			phase    <= next_phase;
			lvl      <= next_lvl;
			cur_bit  <= next_cur_bit;
			cur_last <= next_cur_last;
			pcnt     <= next_pcnt;
			sel_b    <= next_sel_b;
			locked   <= next_locked;
			rstate   <= next_rstate;
			rcnt     <= next_rcnt;
			icnt     <= next_icnt;
			rx_prev  <= rx_in;
			rx_mid   <= next_rx_mid;
			rx_bit   <= next_rx_bit;
			rx_valid <= next_rx_valid;
			bus_idle <= next_bus_idle;
		end
	end

	// Helper: cycles the driven level has stood unchanged
	logic [7:0] run;
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			run <= pdbmc_pkg::CNT_ZERO;
		else if (!drive || lvl != next_lvl)
			run <= pdbmc_pkg::CNT_ZERO;
		else
			run <= run + 8'h01;
	end

	sequence s_last_bit_end;
		state == pdbmc_pkg::S_DATA && cur_last && phase && tick;
	endsequence
	sequence s_close_edge;
		state == pdbmc_pkg::S_CLOSE && lvl != $past(lvl);
	endsequence

	property p_mid_one;
		@(posedge clk_sys) disable iff (rst)
		(drive && state != pdbmc_pkg::S_LEAD && tick && !phase && cur_bit)
		|=> lvl != $past(lvl);
	endproperty
	a_mid_one: assert property (p_mid_one) else $error("no mid edge on one");

	property p_mid_zero;
		@(posedge clk_sys) disable iff (rst)
		(state == pdbmc_pkg::S_DATA && tick && !phase && !cur_bit)
		|=> lvl == $past(lvl) && phase;
	endproperty
	a_mid_zero: assert property (p_mid_zero) else $error("mid edge on zero");

	property p_boundary;
		@(posedge clk_sys) disable iff (rst)
		(state == pdbmc_pkg::S_PRE && tick && phase) |=> lvl != $past(lvl);
	endproperty
	a_boundary: assert property (p_boundary) else $error("no boundary edge");

	property p_run;
		@(posedge clk_sys) disable iff (rst)
		drive |-> run < pdbmc_pkg::BIT_CYC;
	endproperty
	a_run: assert property (p_run) else $error("level held too long");

	property p_lead;
		@(posedge clk_sys) disable iff (rst)
		$rose(drive) |-> lvl == 1'b0 [*8];
	endproperty
	a_lead: assert property (p_lead) else $error("preamble not low first");

	property p_close;
		@(posedge clk_sys) disable iff (rst)
		s_last_bit_end |=> s_close_edge ##[1:40] !drive;
	endproperty
	a_close: assert property (p_close) else $error("no closing edge");

	property p_one_pin;
		@(posedge clk_sys) disable iff (rst)
		!(config_channel_a_oe && config_channel_b_oe)
		&& (config_channel_a_oe || config_channel_b_oe) == drive;
	endproperty
	a_one_pin: assert property (p_one_pin) else $error("pin enables wrong");

	property p_release;
		@(posedge clk_sys) disable iff (rst)
		(state == pdbmc_pkg::S_IDLE || state == pdbmc_pkg::S_WAIT)
		|-> !config_channel_a_oe && !config_channel_b_oe;
	endproperty
	a_release: assert property (p_release) else $error("driver not released");

	property p_orient;
		@(posedge clk_sys) disable iff (rst)
		(locked && attached) |=> sel_b == $past(sel_b);
	endproperty
	a_orient: assert property (p_orient) else $error("pin switched");

	property p_squelch;
		@(posedge clk_sys) disable iff (rst)
		(state == pdbmc_pkg::S_WAIT && !bus_idle && attached)
		|=> state == pdbmc_pkg::S_WAIT;
	endproperty
	a_squelch: assert property (p_squelch) else $error("sent on busy bus");
endmodule : pdbmc_line_coder

`default_nettype wire

// ---- src/pdbmc_pkg.sv ----
package pdbmc_pkg;
	// Half of one unit interval at the 10 MHz system clock
	localparam logic [7:0] HALF_CYC     = 8'h11;
	localparam logic [7:0] BIT_CYC      = 8'h22;
	// Edge later than this after a boundary marks the next boundary
	localparam logic [7:0] RX_MID_LIMIT = 8'h1A;
	// No edge for this long drops the receiver out of lock
	localparam logic [7:0] RX_TIMEOUT   = 8'h2C;
	// Squelch: quiet cycles before the bus counts as idle
	localparam logic [7:0] IDLE_CYC     = 8'h66;
	localparam logic [6:0] PRE_BITS     = 7'h40;
	localparam logic [7:0] CNT_ZERO     = 8'h00;
	localparam logic [6:0] PCNT_ZERO    = 7'h00;

	typedef enum logic [2:0] {
		S_IDLE,
		S_WAIT,
		S_LEAD,
		S_PRE,
		S_DATA,
		S_CLOSE
	} pdbmc_tx_e;

	typedef enum logic {
		R_HUNT,
		R_BIT
	} pdbmc_rx_e;
endpackage : pdbmc_pkg

// ---- tb/pdbmc_far_end.sv ----
`timescale 1ns/10ps
`default_nettype none

module pdbmc_far_end (
	input  wire logic clk_sys, // System clock
	input  wire logic near_oe, // Near end driving
	output logic      far_out, // Drive level
	output logic      far_oe   // Driver enable
);
	initial
	begin
		far_out = 1'b0;
		far_oe = 1'b0;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : hold

	// Lead stays low so the wire shows no first edge
	task automatic send(input logic [31:0] d, input int n);
		while (near_oe) hold(1);
		far_oe = 1'b1;
		far_out = 1'b0;
		hold(17);
		for (int i = 0; i < n; i++)
		begin
			far_out = ~far_out;
			hold(17);
			if (d[i])
				far_out = ~far_out;
			hold(17);
		end
		far_out = ~far_out;
		hold(17);
		far_oe = 1'b0;
	endtask : send
endmodule : pdbmc_far_end

`default_nettype wire

// ---- tb/pdbmc_line_coder_test.sv ----
`timescale 1ns/10ps
`default_nettype none

module pdbmc_line_coder_test;
	logic        clk_sys = 1'b0, rst = 1'b1, sel = 1'b0;
	logic        attached = 1'b0, orient_b = 1'b0;
	logic        tx_start = 1'b0, tx_valid = 1'b0, took = 1'b0;
	logic        tx_bit, tx_last, tx_ready, tx_busy, bus_idle;
	logic        rx_bit, rx_valid, a_in, a_out, a_oe, b_in, b_out, b_oe;
	logic        far_out, far_oe;
	logic [31:0] pay = 32'h0000_0000, seed = 32'h0001_7321, rx_sh;
	logic        lv[$];
	int          idx, rx_n, own_rx, bad_oe, cyc, error_cnt, comparisons;

	// Released wire falls to the pull-down level
	assign a_in = a_oe ? a_out : (far_oe & ~sel & far_out);
	assign b_in = b_oe ? b_out : (far_oe & sel & far_out);
	assign tx_bit = pay[idx[4:0]];
	assign tx_last = (idx == 7);

	always #50 clk_sys = ~clk_sys;

	pdbmc_line_coder u_pdbmc_line_coder (
		.clk_sys(clk_sys), .rst(rst), .attached(attached),
		.orient_b(orient_b), .tx_start(tx_start), .tx_valid(tx_valid),
		.tx_bit(tx_bit), .tx_last(tx_last), .tx_ready(tx_ready),
		.tx_busy(tx_busy), .config_channel_a_in(a_in),
		.config_channel_a_out(a_out), .config_channel_a_oe(a_oe),
		.config_channel_b_in(b_in), .config_channel_b_out(b_out),
		.config_channel_b_oe(b_oe), .bus_idle(bus_idle),
		.rx_bit(rx_bit), .rx_valid(rx_valid)
	);

	pdbmc_far_end u_pdbmc_far_end (
		.clk_sys(clk_sys), .near_oe(a_oe | b_oe),
		.far_out(far_out), .far_oe(far_oe)
	);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic test_done();
		$display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done

	// Lead, 64 preamble bits, 8 payload bits, closing half bit
	task automatic check_tx();
		int e1 = 0;
		int e2 = 0;
		int e3 = 0;
		int s = 0;
		chk(lv.size(), 17 + 34 * 72 + 17);
		for (int k = 0; k < 17; k++)
			if (lv[k] !== 1'b0) e1++;
		for (int b = 0; b < 72; b++)
		begin
			s = 17 + 34 * b;
			if (lv[s] === lv[s - 1]) e2++;
			if ((lv[s + 17] !== lv[s + 16]) !== (b < 64 ? b[0] : pay[b - 64]))
				e3++;
		end
		chk(e1, 0);
		chk(e2, 0);
		chk(e3, 0);
		chk(lv[s + 34] !== lv[s + 33], 1);
	endtask : check_tx

	// Monitors sample the registered line levels each rising edge
	always @(posedge clk_sys)
	begin
		cyc++;
		if (sel ? b_oe : a_oe) lv.push_back(sel ? b_out : a_out);
		if ((sel ? a_oe : b_oe) !== 1'b0) bad_oe++;
		if (rx_valid === 1'b1 && (a_oe | b_oe)) own_rx++;
		if (rx_valid === 1'b1)
		begin
			rx_sh = {rx_bit, rx_sh[31:1]};
			rx_n++;
		end
		if (cyc == 20000)
		begin
			error_cnt++;
			test_done();
		end
	end

	always @(negedge clk_sys) took = tx_ready & tx_valid;

	always @(posedge clk_sys)
	begin
		#1;
		if (took === 1'b1) idx++;
	end

	initial
	begin
		step(16);
		rst = 1'b0;
		chk({a_oe, b_oe, tx_busy}, 3'h0);
		for (int ob = 0; ob < 2; ob++)
		begin
			attached = 1'b0;
			step(3);
			orient_b = ob[0];
			sel = ob[0];
			attached = 1'b1;
			step(3);
			orient_b = ~sel;
			seed = lfsr(seed);
			pay = seed;
			lv.delete();
			idx = 0;
			bad_oe = 0;
			tx_valid = 1'b1;
			tx_start = 1'b1;
			step(1);
			tx_start = 1'b0;
			for (int w = 0; w < 4000 && tx_busy !== 1'b0; w++) step(1);
			tx_valid = 1'b0;
			check_tx();
			chk(bad_oe, 0);
			$display("tx test on pin %0d done", ob);
		end
		// Start while unattached is refused
		attached = 1'b0;
		tx_start = 1'b1;
		step(2);
		chk(tx_busy, 0);
		tx_start = 1'b0;
		orient_b = sel;
		attached = 1'b1;
		step(3);
		// No payload offered: preamble only, then the closing edge
		lv.delete();
		tx_valid = 1'b0;
		tx_start = 1'b1;
		step(1);
		tx_start = 1'b0;
		for (int w = 0; w < 4000 && tx_busy !== 1'b0; w++) step(1);
		chk(lv.size(), 17 + 34 * 64 + 17);
		chk(lv[17 + 34 * 64] !== lv[16 + 34 * 64], 1);
		chk(bad_oe, 0);
		$display("underrun test done");
		chk(own_rx, 0);
		seed = lfsr(seed);
		pay = {16'h0000, seed[7:0], 8'hAA};
		// Release edge of our own driver must age out before the far end talks
		for (int w = 0; w < 200 && bus_idle !== 1'b1; w++) step(1);
		rx_n = 0;
		u_pdbmc_far_end.send(pay, 16);
		step(3);
		chk(rx_n, 16);
		chk(rx_sh[31:16], pay[15:0]);
		chk(bus_idle, 0);
		step(110);
		chk(bus_idle, 1);
		$display("rx test done");
		test_done();
	end
endmodule : pdbmc_line_coder_test

`default_nettype wire
